// ==== verilog/charger_ctrl_regs.sv ====
// Purpose: input-detect/ship and power-path control register pair
// Assumes: host access by addressed byte strobes, synchronous to clk
// Notes: watchdog expiry arrives as a one-cycle pulse from outside
//
// Function
// - Detect and ship control register at 0x11, resets to 0x40.
// - Power-path mode register at 0x12, resets to zero.
// - Force detect bit starts detection, self-clears on completion or watchdog.
// - Auto detect bit enables detection on plug-in; defaults and watchdogs to 1.
// - Twelve and nine volt request steps allowed only when their bits set.
// - High-voltage adapter handshake runs only while its enable bit is 1.
// - Ship action field: idle, shutdown, ship mode, system power reset.
// - Ship action waits 10 s unless the delay skip bit is set.
// - Gate drivers off bit forces both gate driver enables low.
// - Reverse supply enable turns reverse mode on; watchdog clears it.
// - Reverse light-load pulse disable bit; watchdog clears it.
// - Forward light-load pulse disable bit, enabled by default.
// - Ship wake needs the button low 1 s, or 15 ms when selected.
// - Precharge linear mode disable bit; watchdog clears it.
// - Reverse audio floor disable bit; watchdog clears it.
// - Forward audio floor disable bit, enabled by default.
// - Watchdog expiry restores the watchdog-resettable fields to defaults.
`include "charger_ctrl_map.svh"
module charger_ctrl_regs #(
   parameter int MS_TICK = `MS_TICK_CYCLES,
   parameter int SHIP_DELAY_MS = `SHIP_DELAY_MS,
   parameter int WAKE_LONG_MS = `WAKE_LONG_MS,
   parameter int WAKE_SHORT_MS = `WAKE_SHORT_MS
) (
   input wire logic clk,
   input wire logic srst,
   // host byte access
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   output logic [7:0] regReadData,
   output logic regReadValid,
   // system events
   input wire logic watchdogExpired,
   input wire logic supplyPlugged,
   input wire logic detectDone,
   input wire logic gateDriverOneReq,
   input wire logic gateDriverTwoReq,
   input wire logic inShipMode,
   input wire logic wakeButtonPin_n,
   // outputs to the converter logic
   output logic portDetectStart,
   output charger_ctrl_pkg::converter_ctrl_t converterCtrl,
   output logic shutdownRequest,
   output logic shipRequest,
   output logic powerResetRequest,
   output logic shipWake
);
   charger_ctrl_pkg::detect_ship_t detectShip_reg;
   charger_ctrl_pkg::power_path_t powerPath_reg;
   charger_ctrl_pkg::action_state_t actState_reg;
   charger_ctrl_pkg::ship_action_t pendingAction_reg;
   logic writeDs;
   logic writePp;
   logic plugged_reg;
   logic forceRise;
   logic delayDone;
   logic wakeDone;
   logic wakeRunning;
   logic startDelay;
   logic abortDelay;
   logic [17:0] wakeLoadMs;

   assign writeDs = regWrite && (regAddr == `DETECT_SHIP_OFFSET);
   assign writePp = regWrite && (regAddr == `POWER_PATH_OFFSET);

   // force detect starts only on a written 0->1 edge
   assign forceRise = writeDs && regWriteData[`DS_FORCE_DETECT] &&
                      !detectShip_reg.forcePortDetect;

   // register 0x11
   always_ff @(posedge clk) begin
      if (srst) begin
         detectShip_reg <= charger_ctrl_pkg::detect_ship_t'(`DETECT_SHIP_RESET);
      end else begin
         if (writeDs) begin
            detectShip_reg <= charger_ctrl_pkg::detect_ship_t'(regWriteData);
         end else if (startDelay) begin
            // request taken; field reads back idle once consumed
            detectShip_reg.shipSwitchAction <= charger_ctrl_pkg::SHIP_IDLE;
         end
         // watchdog wins over a write in the same cycle; completion does too, except over a 0->1 force write
         if (detectDone && !forceRise) begin
            detectShip_reg.forcePortDetect <= 1'b0;
         end
         if (watchdogExpired) begin
            detectShip_reg <= charger_ctrl_pkg::detect_ship_t'(
               (8'(detectShip_reg) & ~`DS_WDOG_MASK) | `DS_WDOG_VALUE);
         end
      end
   end

   // register 0x12
   always_ff @(posedge clk) begin
      if (srst) begin
         powerPath_reg <= charger_ctrl_pkg::power_path_t'(`POWER_PATH_RESET);
      end else if (watchdogExpired) begin
         powerPath_reg <= charger_ctrl_pkg::power_path_t'(
            (8'(powerPath_reg) & ~`PP_WDOG_MASK) | `PP_WDOG_VALUE);
      end else if (writePp) begin
         powerPath_reg <= charger_ctrl_pkg::power_path_t'(regWriteData);
      end
   end

   // read port answers one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk) begin
      if (srst) begin
         regReadData <= 8'h00;
         regReadValid <= 1'b0;
      end else begin
         regReadValid <= regRead;
         if (regRead) begin
            case (regAddr)
               `DETECT_SHIP_OFFSET: regReadData <= 8'(detectShip_reg);
               `POWER_PATH_OFFSET: regReadData <= 8'(powerPath_reg);
               default: regReadData <= 8'h00;
            endcase
         end
      end
   end

   // detection start: forced, or automatic on plug-in
   always_ff @(posedge clk) begin
      if (srst) begin
         plugged_reg <= 1'b0;
         portDetectStart <= 1'b0;
      end else begin
         plugged_reg <= supplyPlugged;
         portDetectStart <= forceRise ||
            (supplyPlugged && !plugged_reg && detectShip_reg.autoPortDetect);
      end
   end

   // converter steering
   always_ff @(posedge clk) begin
      if (srst) begin
         converterCtrl <= '0;
      end else begin
         converterCtrl.handshakeEnable <= detectShip_reg.highVoltageAdapterHandshake;
         converterCtrl.twelveVoltAllowed <= detectShip_reg.highVoltageAdapterHandshake &&
                                            detectShip_reg.allowTwelveVoltRequest;
         converterCtrl.nineVoltAllowed <= detectShip_reg.highVoltageAdapterHandshake &&
                                          detectShip_reg.allowNineVoltRequest;
         converterCtrl.gateDriverOne <= gateDriverOneReq &&
                                        !powerPath_reg.inputGateDriversOff;
         converterCtrl.gateDriverTwo <= gateDriverTwoReq &&
                                        !powerPath_reg.inputGateDriversOff;
         converterCtrl.reverseOn <= powerPath_reg.reverseSupplyEnable;
         converterCtrl.reversePulseAllowed <= !powerPath_reg.reverseLightLoadPulseOff;
         converterCtrl.forwardPulseAllowed <= !powerPath_reg.forwardLightLoadPulseOff;
         converterCtrl.prechargeLinearAllowed <= !powerPath_reg.prechargeLinearModeOff;
         converterCtrl.reverseAudioFloor <= !powerPath_reg.reverseAudioFloorOff;
         converterCtrl.forwardAudioFloor <= !powerPath_reg.forwardAudioFloorOff;
      end
   end

   // ship action sequencer; one shared timer, so a wake hold and
   // a pending delay never overlap (wake only counts in ship mode)
   assign startDelay = (actState_reg == charger_ctrl_pkg::ACT_IDLE) &&
                       (detectShip_reg.shipSwitchAction != charger_ctrl_pkg::SHIP_IDLE) &&
                       !writeDs && !watchdogExpired;
   // a pending request written back to idle is withdrawn
   assign abortDelay = (actState_reg == charger_ctrl_pkg::ACT_WAIT) && writeDs &&
      (regWriteData[`DS_SHIP_ACTION_HI:`DS_SHIP_ACTION_LO] == 2'h0);

   always_ff @(posedge clk) begin
      if (srst) begin
         actState_reg <= charger_ctrl_pkg::ACT_IDLE;
         pendingAction_reg <= charger_ctrl_pkg::SHIP_IDLE;
      end else begin
         case (actState_reg)
            charger_ctrl_pkg::ACT_IDLE: begin
               if (startDelay) begin
                  pendingAction_reg <= detectShip_reg.shipSwitchAction;
                  actState_reg <= detectShip_reg.shipActionDelaySkip ?
                                  charger_ctrl_pkg::ACT_FIRE :
                                  charger_ctrl_pkg::ACT_WAIT;
               end
            end
            charger_ctrl_pkg::ACT_WAIT: begin
               if (abortDelay) begin
                  actState_reg <= charger_ctrl_pkg::ACT_IDLE;
               end else if (delayDone) begin
                  actState_reg <= charger_ctrl_pkg::ACT_FIRE;
               end
            end
            charger_ctrl_pkg::ACT_FIRE: begin
               actState_reg <= charger_ctrl_pkg::ACT_IDLE;
            end
            default: actState_reg <= charger_ctrl_pkg::ACT_IDLE;
         endcase
      end
   end

   // one-cycle action pulses
   always_ff @(posedge clk) begin
      if (srst) begin
         shutdownRequest <= 1'b0;
         shipRequest <= 1'b0;
         powerResetRequest <= 1'b0;
      end else begin
         shutdownRequest <= (actState_reg == charger_ctrl_pkg::ACT_FIRE) &&
                            (pendingAction_reg == charger_ctrl_pkg::SHIP_SHUTDOWN);
         shipRequest <= (actState_reg == charger_ctrl_pkg::ACT_FIRE) &&
                        (pendingAction_reg == charger_ctrl_pkg::SHIP_SHIP);
         powerResetRequest <= (actState_reg == charger_ctrl_pkg::ACT_FIRE) &&
                              (pendingAction_reg == charger_ctrl_pkg::SHIP_POWER_RESET);
      end
   end

   // wake hold: timer loads on button press in ship mode, aborts on release
   logic wakeLoad;
   logic wakeAbort;
   logic timerLoad;
   logic [17:0] timerLoadMs;
   logic timerAbort;
   logic timerDone;
   logic button_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         button_reg <= 1'b1;
      end else begin
         button_reg <= wakeButtonPin_n;
      end
   end

   assign wakeLoadMs = powerPath_reg.wakeHoldSelect ? 18'(WAKE_SHORT_MS) :
                       18'(WAKE_LONG_MS);
   // a ship delay takes the shared timer from a wake hold, never the reverse;
   // otherwise a button release would abort the pending ship delay
   logic shipDelayLoad;
   assign shipDelayLoad = startDelay && !detectShip_reg.shipActionDelaySkip;
   assign wakeLoad = inShipMode && !wakeButtonPin_n && button_reg && !shipDelayLoad &&
                     (actState_reg != charger_ctrl_pkg::ACT_WAIT);
   assign wakeAbort = wakeRunning && (wakeButtonPin_n || !inShipMode);
   assign timerLoad = shipDelayLoad || wakeLoad;
   assign timerLoadMs = wakeLoad ? wakeLoadMs : 18'(SHIP_DELAY_MS);
   assign timerAbort = abortDelay || (wakeAbort && !shipDelayLoad);
   assign delayDone = timerDone && (actState_reg == charger_ctrl_pkg::ACT_WAIT);
   assign wakeDone = timerDone && wakeRunning && !wakeButtonPin_n;

   always_ff @(posedge clk) begin
      if (srst) begin
         wakeRunning <= 1'b0;
         shipWake <= 1'b0;
      end else begin
         shipWake <= wakeDone;
         if (wakeLoad) begin
            wakeRunning <= 1'b1;
         end else if (timerDone || wakeAbort || shipDelayLoad) begin
            wakeRunning <= 1'b0;
         end
      end
   end

   ms_timer #(
      .TICK_CYCLES(MS_TICK),
      .MS_WIDTH(18)
   ) ms_timer_i (
      .clk(clk),
      .srst(srst),
      .load(timerLoad),
      .loadMs(timerLoadMs),
      .abort(timerAbort),
      .running(),
      .done(timerDone)
   );
endmodule // charger_ctrl_regs

// ==== verilog/charger_ctrl_map.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 125 MHz clock, 8 ns period
// Notes: times in their own units, cycle counts derived from them
`ifndef CHARGER_CTRL_MAP_SVH
`define CHARGER_CTRL_MAP_SVH
`define DETECT_SHIP_OFFSET 8'h11
`define DETECT_SHIP_RESET 8'h40
`define POWER_PATH_OFFSET 8'h12
`define POWER_PATH_RESET 8'h00
`define DS_FORCE_DETECT 7
`define DS_AUTO_DETECT 6
`define DS_ALLOW_12V 5
`define DS_ALLOW_9V 4
`define DS_HV_HANDSHAKE 3
`define DS_SHIP_ACTION_HI 2
`define DS_SHIP_ACTION_LO 1
`define DS_DELAY_SKIP 0
`define PP_GATES_OFF 7
`define PP_REVERSE_EN 6
`define PP_REV_PULSE_OFF 5
`define PP_FWD_PULSE_OFF 4
`define PP_WAKE_SELECT 3
`define PP_LINEAR_OFF 2
`define PP_REV_AUDIO_OFF 1
`define PP_FWD_AUDIO_OFF 0
// registers bits reset by watchdog expiry, and their watchdog defaults
`define DS_WDOG_MASK 8'hc0
`define DS_WDOG_VALUE 8'h40
`define PP_WDOG_MASK 8'h66
`define PP_WDOG_VALUE 8'h00
`define CLK_MHZ 125
`define MS_TICK_CYCLES (1000 * `CLK_MHZ)
`define SHIP_DELAY_S 10
`define SHIP_DELAY_MS (`SHIP_DELAY_S * 1000)
`define WAKE_LONG_S 1
`define WAKE_LONG_MS (`WAKE_LONG_S * 1000)
`define WAKE_SHORT_MS 15
`define WDOG_SETTING_RESET 3'h5
`endif

// ==== verilog/charger_ctrl_pkg.sv ====
// Purpose: types shared by the charger control register pair
// Assumes: nothing beyond the map header
// Notes: field structs mirror the register bit order
package charger_ctrl_pkg;
   typedef enum logic [1:0] {
      SHIP_IDLE = 2'h0,
      SHIP_SHUTDOWN = 2'h1,
      SHIP_SHIP = 2'h2,
      SHIP_POWER_RESET = 2'h3
   } ship_action_t;
   typedef struct packed {
      logic forcePortDetect;
      logic autoPortDetect;
      logic allowTwelveVoltRequest;
      logic allowNineVoltRequest;
      logic highVoltageAdapterHandshake;
      ship_action_t shipSwitchAction;
      logic shipActionDelaySkip;
   } detect_ship_t;
   typedef struct packed {
      logic inputGateDriversOff;
      logic reverseSupplyEnable;
      logic reverseLightLoadPulseOff;
      logic forwardLightLoadPulseOff;
      logic wakeHoldSelect;
      logic prechargeLinearModeOff;
      logic reverseAudioFloorOff;
      logic forwardAudioFloorOff;
   } power_path_t;
   typedef struct packed {
      logic twelveVoltAllowed;
      logic nineVoltAllowed;
      logic handshakeEnable;
      logic reverseOn;
      logic reversePulseAllowed;
      logic forwardPulseAllowed;
      logic prechargeLinearAllowed;
      logic reverseAudioFloor;
      logic forwardAudioFloor;
      logic gateDriverOne;
      logic gateDriverTwo;
   } converter_ctrl_t;
   typedef enum logic [1:0] {
      ACT_IDLE = 2'b00,
      ACT_WAIT = 2'b01,
      ACT_FIRE = 2'b11
   } action_state_t;
endpackage

// ==== verilog/ms_timer.sv ====
// Purpose: millisecond tick divider and down-counter of milliseconds
// Assumes: single clock, synchronous reset
// Notes: done pulses one cycle when a loaded count expires
`include "charger_ctrl_map.svh"
module ms_timer #(
   parameter int TICK_CYCLES = `MS_TICK_CYCLES,
   parameter int MS_WIDTH = 18
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic load,
   input wire logic [MS_WIDTH-1:0] loadMs,
   input wire logic abort,
   output logic running,
   output logic done
);
   logic [31:0] divReg;
   logic [MS_WIDTH-1:0] msReg;
   logic tick;

   // divider restarts on load so the first millisecond is whole
   assign tick = (divReg == 32'(TICK_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (srst || load || abort || !running || tick) begin
         divReg <= 32'h0;
      end else begin
         divReg <= divReg + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || abort) begin
         msReg <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end else if (load) begin
         msReg <= loadMs;
         running <= 1'b1;
         done <= 1'b0;
      end else if (running && tick) begin
         msReg <= msReg - MS_WIDTH'(1);
         running <= (msReg > MS_WIDTH'(1));
         done <= (msReg <= MS_WIDTH'(1));
      end else begin
         done <= 1'b0;
      end
   end
endmodule // ms_timer

// ==== verif/charger_ctrl_props.sv ====
// Purpose: port-level checks for the control register pair
// Assumes: parameters equal those of the bound instance
// Notes: register state is not visible, so checks tie outputs to input causes
module charger_ctrl_props #(
   parameter int MS_TICK = 4,
   parameter int WAKE_SHORT_MS = 2
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid,
   input wire logic watchdogExpired,
   input wire logic supplyPlugged,
   input wire logic gateDriverOneReq,
   input wire logic wakeButtonPin_n,
   input wire logic portDetectStart,
   input wire charger_ctrl_pkg::converter_ctrl_t converterCtrl,
   input wire logic shutdownRequest,
   input wire logic shipRequest,
   input wire logic powerResetRequest,
   input wire logic shipWake
);
   timeunit 1ns;
   timeprecision 100ps;
   logic plugPrev;
   logic anyReq;
   logic detCause;
   logic [1:0] reqCode;
   int lowCnt;
   assign anyReq = shutdownRequest | shipRequest | powerResetRequest;
   assign reqCode = {powerResetRequest | shipRequest, powerResetRequest | shutdownRequest};
   assign detCause = (regWrite && regAddr == 8'h11 && regWriteData[7]) ||
      (supplyPlugged && !plugPrev);
   always_ff @(posedge clk) begin
      plugPrev <= supplyPlugged;
   end
   // tick phase restarts on each timer load; the check still allows one ms of slack
   always_ff @(posedge clk) begin
      lowCnt <= wakeButtonPin_n ? 0 : lowCnt + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence shipWrite(bit skip);
      regWrite && regAddr == 8'h11 && regWriteData[2:1] != 2'h0 &&
         regWriteData[0] == skip && !watchdogExpired;
   endsequence
   read_answer_a: assert property (regRead |=> regReadValid)
      else $error("read not answered");
   read_pulse_a: assert property (!regRead |=> !regReadValid)
      else $error("read valid without read");
   unmapped_zero_a: assert property (regRead && regAddr != 8'h11 && regAddr != 8'h12
      |=> regReadData == 8'h00) else $error("unmapped read not zero");
   handshake_gate_a: assert property (converterCtrl.twelveVoltAllowed ||
      converterCtrl.nineVoltAllowed |-> converterCtrl.handshakeEnable)
      else $error("voltage step without handshake");
   gate_follow_a: assert property (converterCtrl.gateDriverOne |-> $past(gateDriverOneReq))
      else $error("gate driver without request");
   ship_pulse_a: assert property (anyReq |-> $onehot(reqCode ^ {1'b0, 1'b0}) ||
      powerResetRequest ##1 !anyReq) else $error("ship request not single pulse");
   ship_fast_a: assert property (shipWrite(1'b1) |-> ##3 reqCode == $past(regWriteData[2:1], 3))
      else $error("undelayed ship action wrong");
   ship_wait_a: assert property (shipWrite(1'b0) |=> (!anyReq)[*8])
      else $error("delayed ship action too early");
   detect_cause_a: assert property (portDetectStart |-> $past(detCause) || $past(detCause, 2))
      else $error("detect start without cause");
   wake_hold_a: assert property (shipWake |-> lowCnt >= (WAKE_SHORT_MS - 1) * MS_TICK)
      else $error("wake with short button hold");
endmodule // charger_ctrl_props

// ==== verif/host_model.sv ====
// Purpose: host side of the byte register access
// Assumes: tasks are entered between edges, one access at a time
// Notes: idle address and data lines flip so stale values never look valid
module host_model (
   input wire logic clk,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWriteData,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWriteData = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWriteData <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regReadValid ? regReadData : 8'hxx;
   endtask
endmodule // host_model

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for the control register pair
// Assumes: ms tick and delays shortened by parameters
// Notes: host traffic goes through the host model tasks
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK = 4;
   localparam int DLY = 3;
   localparam int LONG = 5;
   localparam int SHORT = 2;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic watchdogExpired = 1'b0;
   logic supplyPlugged = 1'b0;
   logic detectDone = 1'b0;
   logic inShipMode = 1'b0;
   logic wakeButtonPin_n = 1'b1;
   logic gateReq = 1'b1;
   logic regWrite, regRead, regReadValid;
   logic [7:0] regAddr, regWriteData, regReadData, rdv;
   logic portDetectStart, shutdownRequest, shipRequest, powerResetRequest, shipWake;
   logic [1:0] lastReq = 2'h0;
   charger_ctrl_pkg::converter_ctrl_t converterCtrl;
   int errors = 0;
   int compares = 0;
   int detN = 0;
   int reqN = 0;
   int wakeN = 0;
   always #4 clk = ~clk;
   charger_ctrl_regs #(.MS_TICK(TICK), .SHIP_DELAY_MS(DLY), .WAKE_LONG_MS(LONG),
      .WAKE_SHORT_MS(SHORT)) charger_ctrl_regs_i (.clk(clk), .srst(srst),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
      .regReadData(regReadData), .regReadValid(regReadValid),
      .watchdogExpired(watchdogExpired), .supplyPlugged(supplyPlugged),
      .detectDone(detectDone), .gateDriverOneReq(gateReq), .gateDriverTwoReq(gateReq),
      .inShipMode(inShipMode), .wakeButtonPin_n(wakeButtonPin_n),
      .portDetectStart(portDetectStart), .converterCtrl(converterCtrl),
      .shutdownRequest(shutdownRequest), .shipRequest(shipRequest),
      .powerResetRequest(powerResetRequest), .shipWake(shipWake));
   host_model host_model_i (.clk(clk), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
      .regReadValid(regReadValid));
   always @(posedge clk) begin
      detN <= detN + int'(portDetectStart);
      wakeN <= wakeN + int'(shipWake);
      if (shutdownRequest | shipRequest | powerResetRequest) begin
         reqN <= reqN + 1;
         lastReq <= {powerResetRequest | shipRequest, powerResetRequest | shutdownRequest};
      end
   end
   task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host_model_i.rd(a, rdv);
      chk("register byte", {3'h0, e}, {3'h0, rdv});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      rdc(8'h11, 8'h40);
      rdc(8'h12, 8'h00);
      rdc(8'h13, 8'h00);
      host_model_i.wr(8'h13, 8'hff);
      rdc(8'h12, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_path;
      host_model_i.wr(8'h12, 8'hff);
      rdc(8'h12, 8'hff);
      chk("converter ctrl", 11'h080, converterCtrl);
      host_model_i.wr(8'h12, 8'h00);
      cyc(2);
      chk("converter ctrl", 11'h07f, converterCtrl);
      @(posedge clk) gateReq <= 1'b0;
      cyc(2);
      chk("converter ctrl", 11'h07c, converterCtrl);
      @(posedge clk) gateReq <= 1'b1;
      $display("power path test done");
   endtask
   task automatic t_wdog;
      host_model_i.wr(8'h12, 8'hff);
      host_model_i.wr(8'h11, 8'hb8);
      @(posedge clk) watchdogExpired <= 1'b1;
      @(posedge clk) watchdogExpired <= 1'b0;
      rdc(8'h11, 8'h78);
      rdc(8'h12, 8'h99);
      chk("converter ctrl", 11'h758, converterCtrl);
      host_model_i.wr(8'h11, 8'h30);
      cyc(2);
      chk("converter ctrl", 11'h058, converterCtrl);
      $display("watchdog test done");
   endtask
   task automatic t_detect;
      int n;
      host_model_i.wr(8'h11, 8'h40);
      n = detN;
      host_model_i.wr(8'h11, 8'hc0);
      cyc(3);
      chk("detect starts", 11'h1, 11'(detN - n));
      rdc(8'h11, 8'hc0);
      @(posedge clk) detectDone <= 1'b1;
      @(posedge clk) detectDone <= 1'b0;
      rdc(8'h11, 8'h40);
      @(posedge clk) supplyPlugged <= 1'b1;
      cyc(3);
      chk("detect starts", 11'h2, 11'(detN - n));
      @(posedge clk) supplyPlugged <= 1'b0;
      host_model_i.wr(8'h11, 8'h00);
      @(posedge clk) supplyPlugged <= 1'b1;
      cyc(3);
      chk("detect starts", 11'h2, 11'(detN - n));
      @(posedge clk) supplyPlugged <= 1'b0;
      $display("detect test done");
   endtask
   task automatic t_ship;
      int n;
      for (int c = 1; c < 4; c++) begin
         n = reqN;
         host_model_i.wr(8'h11, 8'h41 | 8'(c << 1));
         cyc(4);
         chk("ship action", 11'(c), {9'h0, lastReq});
         chk("ship count", 11'(n + 1), 11'(reqN));
         rdc(8'h11, 8'h41);
      end
      n = reqN;
      host_model_i.wr(8'h11, 8'h44);
      cyc(DLY * TICK - 2);
      chk("early action", 11'(n), 11'(reqN));
      cyc(40);
      chk("late action", 11'(n + 1), 11'(reqN));
      host_model_i.wr(8'h11, 8'h42);
      cyc(4);
      // a zero field while waiting must cancel the pending action
      host_model_i.wr(8'h11, 8'h40);
      cyc(60);
      chk("aborted action", 11'(n + 1), 11'(reqN));
      $display("ship test done");
   endtask
   task automatic t_wake;
      int n;
      n = wakeN;
      host_model_i.wr(8'h12, 8'h08);
      @(posedge clk) inShipMode <= 1'b1;
      @(posedge clk) wakeButtonPin_n <= 1'b0;
      cyc(SHORT * TICK + 6);
      @(posedge clk) wakeButtonPin_n <= 1'b1;
      cyc(2);
      chk("wake count", 11'(n + 1), 11'(wakeN));
      host_model_i.wr(8'h12, 8'h00);
      @(posedge clk) wakeButtonPin_n <= 1'b0;
      cyc((LONG - 1) * TICK - 2);
      @(posedge clk) wakeButtonPin_n <= 1'b1;
      cyc(2);
      chk("wake count", 11'(n + 1), 11'(wakeN));
      @(posedge clk) wakeButtonPin_n <= 1'b0;
      cyc(LONG * TICK + 8);
      @(posedge clk) wakeButtonPin_n <= 1'b1;
      cyc(2);
      chk("wake count", 11'(n + 2), 11'(wakeN));
      $display("wake test done");
   endtask
   task automatic end_sim;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_path();
      t_wdog();
      t_detect();
      t_ship();
      t_wake();
      end_sim();
   end
   initial begin
      #(4000 * 8);
      errors++;
      end_sim();
   end
endmodule // tb_top
bind charger_ctrl_regs charger_ctrl_props #(.MS_TICK(MS_TICK), .WAKE_SHORT_MS(WAKE_SHORT_MS))
   charger_ctrl_props_i (.clk(clk), .srst(srst), .regWrite(regWrite), .regRead(regRead),
   .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
   .regReadValid(regReadValid), .watchdogExpired(watchdogExpired),
   .supplyPlugged(supplyPlugged), .gateDriverOneReq(gateDriverOneReq),
   .wakeButtonPin_n(wakeButtonPin_n), .portDetectStart(portDetectStart),
   .converterCtrl(converterCtrl), .shutdownRequest(shutdownRequest),
   .shipRequest(shipRequest), .powerResetRequest(powerResetRequest), .shipWake(shipWake));
